// ==== hdl/dmm_pkg.sv ====
// Purpose: Shared constants and types for the data memory map access block
// Assumes: 16-bit data address space, byte wide data memory
// Notes: Region bounds, cycle costs and mode encodings live here only
package dmm_pkg;

    // Data space region bounds
    localparam logic [15:0] STDIO_BASE = 16'h0020;
    localparam logic [15:0] EXTIO_BASE = 16'h0060;
    localparam logic [15:0] EXTIO_LAST = 16'h00FF;
    localparam logic [15:0] SRAM_BASE_NORM = 16'h0100;
    localparam logic [15:0] SRAM_BASE_COMPAT = 16'h0060;
    localparam logic [15:0] INT_TOP_NORM = 16'h1100;
    localparam logic [15:0] INT_TOP_COMPAT = 16'h1000;
    localparam int SRAM_DEPTH_NORM = 4096;
    localparam int SRAM_IDX_W = 12;

    // Short I/O port numbers sit this far above the register file
    localparam logic [15:0] IO_PORT_OFS = 16'h0020;

    // Pointer registers occupy register file locations 26 to 31
    localparam logic [4:0] PTR_BASE = 5'h1A;

    // Access cycle costs
    localparam logic [3:0] INT_BYTE_CYC = 4'h2;
    localparam logic [3:0] INT_PIPE_CYC = 4'h1;
    localparam logic [3:0] EXT_EXTRA_CYC = 4'h1;
    localparam logic [1:0] WS_MAX_COMPAT = 2'h1;

    // Pointer select codes
    localparam logic [1:0] PS_X = 2'h0;
    localparam logic [1:0] PS_Y = 2'h1;
    localparam logic [1:0] PS_Z = 2'h2;

    typedef enum logic [2:0] {
        RG_REGFILE,
        RG_STDIO,
        RG_EXTIO,
        RG_SRAM,
        RG_EXT,
        RG_NONE
    } dmm_region_t;

    typedef enum logic [2:0] {
        AM_DIRECT,
        AM_DISP,
        AM_IND,
        AM_PREDEC,
        AM_POSTINC
    } dmm_mode_t;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_BUSY
    } dmm_state_t;

endpackage : dmm_pkg

// ==== hdl/dmm_dec_if.sv ====
// Purpose: Carries an address to the region decoder and its answer back
// Assumes: Purely combinational path inside one clock domain
// Notes: core drives the address, dec answers with region and SRAM index
`timescale 1ns/1ns
interface dmm_dec_if;
    logic [15:0] addr;
    logic compat;
    logic ext_en;
    dmm_pkg::dmm_region_t region;
    logic [dmm_pkg::SRAM_IDX_W-1:0] sram_idx;

    modport core (output addr, output compat, output ext_en, input region, input sram_idx);
    modport dec (input addr, input compat, input ext_en, output region, output sram_idx);
endinterface : dmm_dec_if

// ==== hdl/dmm_decode.sv ====
// Purpose: Classifies a data address into its memory map region
// Assumes: Address already formed by the access engine
// Notes: No state; the layout depends on the compatibility mode
`timescale 1ns/1ns
module dmm_decode (
    dmm_dec_if.dec d
);
    logic [15:0] top;
    logic [15:0] sbase;
    logic [15:0] idx_full;

    // Region order: register file, standard I/O, extended I/O, SRAM, external
    always_comb begin
        top = d.compat ? dmm_pkg::INT_TOP_COMPAT : dmm_pkg::INT_TOP_NORM;
        sbase = d.compat ? dmm_pkg::SRAM_BASE_COMPAT : dmm_pkg::SRAM_BASE_NORM;
        idx_full = d.addr - sbase;
        d.sram_idx = idx_full[dmm_pkg::SRAM_IDX_W-1:0];
        if (d.addr < dmm_pkg::STDIO_BASE) begin
            d.region = dmm_pkg::RG_REGFILE;
        end else if (d.addr < dmm_pkg::EXTIO_BASE) begin
            d.region = dmm_pkg::RG_STDIO;
        end else if (!d.compat && d.addr <= dmm_pkg::EXTIO_LAST) begin
            d.region = dmm_pkg::RG_EXTIO;
        end else if (d.addr < top) begin
            d.region = dmm_pkg::RG_SRAM;
        end else if (d.ext_en) begin
            d.region = dmm_pkg::RG_EXT;
        end else begin
            d.region = dmm_pkg::RG_NONE;
        end
    end

endmodule : dmm_decode

// ==== hdl/dmm_data_access.sv ====
// Purpose: Data space access engine with internal SRAM and external strobes
// Assumes: One CPU clock, requests from same-clock CPU logic, static config inputs
// Notes: Holds the X, Y and Z pointers and the internal SRAM array
`timescale 1ns/1ns

module dmm_data_access #(
    parameter int SRAM_DEPTH = dmm_pkg::SRAM_DEPTH_NORM
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic REQ,
    input wire logic WE,
    input wire logic TWO_BYTE,
    input wire logic IO_INSN,
    input wire logic [2:0] MODE,
    input wire logic [1:0] PTR_SEL,
    input wire logic [5:0] DISP,
    input wire logic [15:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic EXT_ENABLE,
    input wire logic COMPAT_MODE,
    input wire logic [1:0] WAIT_SEL,
    input wire logic [7:0] LOC_RDATA,
    input wire logic [7:0] EXT_DATA_I,
    output logic BUSY,
    output logic DONE,
    output logic [15:0] RDATA,
    output logic [2:0] REGION,
    output logic EXT_BLOCKED,
    output logic [15:0] PTR_X,
    output logic [15:0] PTR_Y,
    output logic [15:0] PTR_Z,
    output logic LOC_SEL,
    output logic LOC_WE,
    output logic [7:0] LOC_ADDR,
    output logic [7:0] LOC_WDATA,
    output logic [15:0] EXT_ADDR,
    output logic EXT_RD_N,
    output logic EXT_WR_N,
    output logic [7:0] EXT_DATA_O,
    output logic EXT_DATA_OE_N
);

    typedef struct packed {
        dmm_pkg::dmm_state_t st;
        logic [3:0] cnt;
        logic [3:0] len0;
        logic [3:0] tot;
        logic we;
        logic bsel;
        logic [15:0] ea;
        dmm_pkg::dmm_region_t rg;
        logic [dmm_pkg::SRAM_IDX_W-1:0] idx;
        logic [15:0] wd;
        logic [15:0] rd;
        logic done;
        logic blocked;
        logic [5:0][7:0] ptr;
        logic loc_sel;
        logic loc_we;
        logic [7:0] loc_addr;
        logic [7:0] bus_do;
        logic [15:0] ext_addr;
        logic ext_rd_n;
        logic ext_wr_n;
        logic oe_n;
    } dmm_core_st_t;

    localparam dmm_core_st_t RST_ST = '{
        st: dmm_pkg::ST_IDLE,
        rg: dmm_pkg::RG_NONE,
        ext_rd_n: 1'b1,
        ext_wr_n: 1'b1,
        oe_n: 1'b1,
        default: '0
    };

    dmm_core_st_t cur;
    dmm_core_st_t nxt;
    logic [7:0] mem [SRAM_DEPTH];
    logic mem_we;
    logic [dmm_pkg::SRAM_IDX_W-1:0] mem_idx;
    logic [7:0] mem_wd;

    dmm_dec_if dec_bus ();

    dmm_decode u_decode (
        .d(dec_bus)
    );

    logic take;
    logic byte_end;
    logic [15:0] ptr_val;
    logic [15:0] ea_calc;
    logic [1:0] ws_eff;
    logic [3:0] ext_len;
    logic [15:0] ba;
    logic [7:0] rbyte;
    logic [7:0] wbyte;
    logic [2:0] pidx;
    logic is_ptr;
    logic [3:0] off;
    logic ext_act;

    // Returns the 16-bit pointer chosen by sel from the pointer file
    function automatic logic [15:0] ptr_get(input logic [5:0][7:0] p, input logic [1:0] sel);
        logic [15:0] v;
        v = {p[1], p[0]};
        if (sel == dmm_pkg::PS_Y) begin
            v = {p[3], p[2]};
        end else if (sel == dmm_pkg::PS_Z) begin
            v = {p[5], p[4]};
        end
        return v;
    endfunction : ptr_get

    // Short I/O port number maps only onto the 64 standard I/O locations
    function automatic logic [15:0] io_port_ea(input logic [5:0] port);
        return dmm_pkg::IO_PORT_OFS + {10'h000, port};
    endfunction : io_port_ea

    // Address formation for the access about to be taken
    always_comb begin
        ptr_val = ptr_get(cur.ptr, PTR_SEL);
        ea_calc = ADDR;
        if (IO_INSN) begin
            ea_calc = io_port_ea(ADDR[5:0]);
        end else begin
            case (MODE)
                dmm_pkg::AM_DISP: begin
                    // X has no displacement form, so anything but Z means Y
                    ea_calc = ptr_get(cur.ptr, (PTR_SEL == dmm_pkg::PS_Z) ? dmm_pkg::PS_Z
                                      : dmm_pkg::PS_Y) + {10'h000, DISP};
                end
                dmm_pkg::AM_IND: begin
                    ea_calc = ptr_val;
                end
                dmm_pkg::AM_PREDEC: begin
                    ea_calc = ptr_val - 16'h0001;
                end
                dmm_pkg::AM_POSTINC: begin
                    ea_calc = ptr_val;
                end
                default: begin
                    ea_calc = ADDR;
                end
            endcase
        end
    end

    // Decoder classifies the address formed from this cycle's inputs
    assign dec_bus.addr = ea_calc;
    assign dec_bus.compat = COMPAT_MODE;
    assign dec_bus.ext_en = EXT_ENABLE;

    // Wait state and per-byte length selection
    always_comb begin
        ws_eff = WAIT_SEL;
        if (COMPAT_MODE && WAIT_SEL != 2'h0) begin
            ws_eff = dmm_pkg::WS_MAX_COMPAT;
        end
        ext_len = dmm_pkg::INT_BYTE_CYC + dmm_pkg::EXT_EXTRA_CYC + {2'h0, ws_eff};
    end

    // Byte being moved in the current cycle and what it reads back
    always_comb begin
        ba = cur.ea + {15'h0000, cur.bsel};
        mem_idx = cur.idx + {{(dmm_pkg::SRAM_IDX_W-1){1'b0}}, cur.bsel};
        wbyte = cur.bsel ? cur.wd[15:8] : cur.wd[7:0];
        is_ptr = (cur.rg == dmm_pkg::RG_REGFILE) && (ba[4:0] >= dmm_pkg::PTR_BASE);
        pidx = 3'(ba[4:0] - dmm_pkg::PTR_BASE);
        byte_end = (cur.st == dmm_pkg::ST_BUSY) &&
                   (((cur.cnt == cur.len0 - 4'h1) && !cur.bsel) || (cur.cnt == cur.tot - 4'h1));
        case (cur.rg)
            dmm_pkg::RG_SRAM: rbyte = mem[mem_idx];
            dmm_pkg::RG_EXT: rbyte = EXT_DATA_I;
            dmm_pkg::RG_NONE: rbyte = 8'h00;
            default: rbyte = is_ptr ? cur.ptr[pidx] : LOC_RDATA;
        endcase
        mem_we = byte_end && cur.we && (cur.rg == dmm_pkg::RG_SRAM);
        mem_wd = wbyte;
    end

    // Next state of the access engine
    always_comb begin
        nxt = cur;
        nxt.done = 1'b0;
        nxt.blocked = 1'b0;
        take = REQ && (cur.st == dmm_pkg::ST_IDLE);
        if (take) begin
            nxt.st = dmm_pkg::ST_BUSY;
            nxt.cnt = 4'h0;
            nxt.bsel = 1'b0;
            nxt.we = WE;
            nxt.ea = ea_calc;
            nxt.rg = dec_bus.region;
            nxt.idx = dec_bus.sram_idx;
            nxt.wd = WDATA;
            nxt.rd = 16'h0000;
            if (dec_bus.region == dmm_pkg::RG_EXT) begin
                nxt.len0 = ext_len;
                nxt.tot = TWO_BYTE ? 4'(ext_len + ext_len) : ext_len;
            end else begin
                nxt.len0 = dmm_pkg::INT_BYTE_CYC;
                // Second byte rides the internal pipeline for one cycle
                nxt.tot = TWO_BYTE ? 4'(dmm_pkg::INT_BYTE_CYC + dmm_pkg::INT_PIPE_CYC)
                                   : dmm_pkg::INT_BYTE_CYC;
            end
            if (!IO_INSN && MODE == dmm_pkg::AM_PREDEC) begin
                {nxt.ptr[2*PTR_SEL+1], nxt.ptr[2*PTR_SEL]} = ptr_val - 16'h0001;
            end else if (!IO_INSN && MODE == dmm_pkg::AM_POSTINC) begin
                {nxt.ptr[2*PTR_SEL+1], nxt.ptr[2*PTR_SEL]} = ptr_val + 16'h0001;
            end
        end else if (cur.st == dmm_pkg::ST_BUSY) begin
            if (byte_end) begin
                if (cur.bsel) begin
                    nxt.rd[15:8] = rbyte;
                end else begin
                    nxt.rd[7:0] = rbyte;
                end
                // Stores to R26..R31 land in the pointer file
                if (cur.we && is_ptr) begin
                    nxt.ptr[pidx] = wbyte;
                end
            end
            if (cur.cnt == cur.tot - 4'h1) begin
                nxt.st = dmm_pkg::ST_IDLE;
                nxt.done = 1'b1;
                nxt.blocked = (cur.rg == dmm_pkg::RG_NONE);
            end else begin
                nxt.cnt = cur.cnt + 4'h1;
                if (byte_end) begin
                    nxt.bsel = 1'b1;
                end
            end
        end

        // Pin side, computed from the next state so the outputs are registered
        ext_act = (nxt.st == dmm_pkg::ST_BUSY) && (nxt.rg == dmm_pkg::RG_EXT);
        off = nxt.cnt - (nxt.bsel ? nxt.len0 : 4'h0);
        // First cycle of each byte is address setup with strobes idle
        nxt.ext_rd_n = !(ext_act && !nxt.we && off != 4'h0);
        nxt.ext_wr_n = !(ext_act && nxt.we && off != 4'h0);
        nxt.oe_n = !(ext_act && nxt.we);
        nxt.ext_addr = ext_act ? nxt.ea + {15'h0000, nxt.bsel} : cur.ext_addr;
        nxt.bus_do = nxt.bsel ? nxt.wd[15:8] : nxt.wd[7:0];
        nxt.loc_sel = (nxt.st == dmm_pkg::ST_BUSY) &&
                      ((nxt.rg == dmm_pkg::RG_REGFILE) || (nxt.rg == dmm_pkg::RG_STDIO) ||
                       (nxt.rg == dmm_pkg::RG_EXTIO));
        nxt.loc_we = nxt.loc_sel && nxt.we;
        nxt.loc_addr = 8'(nxt.ea + {15'h0000, nxt.bsel});
    end

    // Engine state register
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cur <= RST_ST;
        end else begin
            cur <= nxt;
        end
    end

    // Internal SRAM array, no reset so it maps onto block memory
    always_ff @(posedge SYS_CLK) begin
        if (mem_we) begin
            mem[mem_idx] <= mem_wd;
        end
    end

    // Outputs straight from the state register
    assign BUSY = (cur.st == dmm_pkg::ST_BUSY);
    assign DONE = cur.done;
    assign RDATA = cur.rd;
    assign REGION = cur.rg;
    assign EXT_BLOCKED = cur.blocked;
    assign PTR_X = {cur.ptr[1], cur.ptr[0]};
    assign PTR_Y = {cur.ptr[3], cur.ptr[2]};
    assign PTR_Z = {cur.ptr[5], cur.ptr[4]};
    assign LOC_SEL = cur.loc_sel;
    assign LOC_WE = cur.loc_we;
    assign LOC_ADDR = cur.loc_addr;
    assign LOC_WDATA = cur.bus_do;
    assign EXT_ADDR = cur.ext_addr;
    assign EXT_RD_N = cur.ext_rd_n;
    assign EXT_WR_N = cur.ext_wr_n;
    assign EXT_DATA_O = cur.bus_do;
    assign EXT_DATA_OE_N = cur.oe_n;

endmodule : dmm_data_access

// ==== sim/dmm_chk.sv ====
// Purpose: Port-level map, strobe and cycle checks for the access engine
// Assumes: Same clock and reset as the engine, config static per access
// Notes: The cycle count runs from the take edge to the done pulse
`timescale 1ns/1ns
module dmm_chk (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic REQ,
    input wire logic TWO_BYTE,
    input wire logic IO_INSN,
    input wire logic [2:0] MODE,
    input wire logic [1:0] PTR_SEL,
    input wire logic [5:0] DISP,
    input wire logic COMPAT_MODE,
    input wire logic [1:0] WAIT_SEL,
    input wire logic EXT_ENABLE,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic [2:0] REGION,
    input wire logic [15:0] PTR_X,
    input wire logic [15:0] PTR_Y,
    input wire logic [15:0] EXT_ADDR,
    input wire logic EXT_RD_N,
    input wire logic EXT_WR_N
);
    logic [4:0] cnt_ff;
    logic [4:0] w_eff;
    logic two_ff, cmp_ff;
    logic [1:0] ws_ff;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // Latch the shape of each taken request and count its cycles
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_ff <= 5'h00;
            two_ff <= 1'h0;
            cmp_ff <= 1'h0;
            ws_ff <= 2'h0;
        end else if (REQ && !BUSY) begin
            cnt_ff <= 5'h00;
            two_ff <= TWO_BYTE;
            cmp_ff <= COMPAT_MODE;
            ws_ff <= WAIT_SEL;
        end else if (BUSY) begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end
    // Compatibility map clamps any nonzero wait setting to one
    assign w_eff = cmp_ff ? {4'h0, |ws_ff} : {3'h0, ws_ff};
    sequence s_take;
        REQ && !BUSY;
    endsequence
    sequence s_ext_end;
        DONE && REGION == 3'h4;
    endsequence
    chk_int_no_strobe: assert property (BUSY && REGION <= 3'h3 |-> EXT_RD_N && EXT_WR_N)
        else $error("strobe during internal access");
    chk_off_no_strobe: assert property (REGION == 3'h5 |-> EXT_RD_N && EXT_WR_N)
        else $error("strobe while external disabled");
    chk_strobe_needs_en: assert property (!EXT_RD_N || !EXT_WR_N |-> EXT_ENABLE && REGION == 3'h4)
        else $error("strobe without enable");
    chk_int_cycles: assert property (DONE && REGION != 3'h4 |-> cnt_ff == (two_ff ? 5'h03 : 5'h02))
        else $error("internal access length");
    chk_ext_single: assert property (s_ext_end and !two_ff |-> cnt_ff == 5'h03 + w_eff)
        else $error("external byte length");
    chk_ext_stack: assert property (s_ext_end and two_ff |-> cnt_ff == 5'h06 + w_eff + w_eff)
        else $error("external pair length");
    chk_compat_wait: assert property (s_ext_end and cmp_ff |-> cnt_ff <= (two_ff ? 5'h08 : 5'h04))
        else $error("compat wait too long");
    chk_io_region: assert property (s_take and IO_INSN |=> REGION == 3'h1)
        else $error("short io left standard io");
    chk_postinc_ptr: assert property (s_take and !IO_INSN && MODE == 3'h4 && PTR_SEL == 2'h0
        |=> PTR_X == $past(PTR_X) + 16'h0001)
        else $error("post increment missing");
    chk_disp_addr: assert property (s_take and !IO_INSN && MODE == 3'h1 && PTR_SEL == 2'h1
        |=> REGION != 3'h4 || EXT_ADDR == $past(PTR_Y) + {10'h000, $past(DISP)})
        else $error("displacement address wrong");
endmodule : dmm_chk

bind dmm_data_access dmm_chk chk_u (.SYS_CLK, .RST_N, .REQ, .TWO_BYTE, .IO_INSN, .MODE,
    .PTR_SEL, .DISP, .COMPAT_MODE, .WAIT_SEL, .EXT_ENABLE, .BUSY, .DONE, .REGION, .PTR_X,
    .PTR_Y, .EXT_ADDR, .EXT_RD_N, .EXT_WR_N);

// ==== sim/dmm_ext_sram.sv ====
// Purpose: Behavioural external SRAM on the strobe bus
// Assumes: Answers every byte at once, low address byte indexes it
// Notes: Released bus shows the inverse of the last byte read
`timescale 1ns/1ns
module dmm_ext_sram (
    input wire logic sys_clk,
    input wire logic [15:0] ext_addr,
    input wire logic ext_rd_n,
    input wire logic ext_wr_n,
    input wire logic [7:0] ext_data_o,
    input wire logic ext_data_oe_n,
    output logic [7:0] ext_data_i
);
    logic [7:0] mem [256];
    logic [7:0] last_q = 8'h00;
    // Store only while both strobe and driver are active
    always_ff @(posedge sys_clk) begin
        if (!ext_wr_n && !ext_data_oe_n) begin
            mem[ext_addr[7:0]] <= ext_data_o;
        end
        if (!ext_rd_n) begin
            last_q <= mem[ext_addr[7:0]];
        end
    end
    // No stale value can pass for a good read once released
    assign ext_data_i = !ext_rd_n ? mem[ext_addr[7:0]] : ~last_q;
endmodule : dmm_ext_sram

// ==== sim/dmm_data_access_tb_top.sv ====
// Purpose: Self-checking bench for the data space access engine
// Assumes: External SRAM model on the far side of the strobe bus
// Notes: Latency is counted from the take edge to the done edge
`timescale 1ns/1ns
module dmm_data_access_tb_top;
    logic SYS_CLK = 1'h0, RST_N = 1'h0, REQ = 1'h0, WE = 1'h0, TWO_BYTE = 1'h0;
    logic IO_INSN = 1'h0, EXT_ENABLE = 1'h1, COMPAT_MODE = 1'h0;
    logic [2:0] MODE = 3'h0;
    logic [1:0] PTR_SEL = 2'h0, WAIT_SEL = 2'h0;
    logic [5:0] DISP = 6'h00;
    logic [15:0] ADDR = 16'h0000, WDATA = 16'h0000;
    logic [7:0] LOC_RDATA = 8'h3C, EXT_DATA_I, LOC_ADDR, LOC_WDATA, EXT_DATA_O;
    logic BUSY, DONE, EXT_BLOCKED, LOC_SEL, LOC_WE, EXT_RD_N, EXT_WR_N, EXT_DATA_OE_N;
    logic [2:0] REGION;
    logic [15:0] RDATA, PTR_X, PTR_Y, PTR_Z, EXT_ADDR, rd;
    int mismatches = 0, comparisons = 0, strobes = 0, lat, locs = 0, loc_writes = 0;
    dmm_data_access dut_u (.SYS_CLK, .RST_N, .REQ, .WE, .TWO_BYTE, .IO_INSN, .MODE, .PTR_SEL,
        .DISP, .ADDR, .WDATA, .EXT_ENABLE, .COMPAT_MODE, .WAIT_SEL, .LOC_RDATA, .EXT_DATA_I,
        .BUSY, .DONE, .RDATA, .REGION, .EXT_BLOCKED, .PTR_X, .PTR_Y, .PTR_Z, .LOC_SEL,
        .LOC_WE, .LOC_ADDR, .LOC_WDATA, .EXT_ADDR, .EXT_RD_N, .EXT_WR_N, .EXT_DATA_O,
        .EXT_DATA_OE_N);
    dmm_ext_sram ext_u (.sys_clk(SYS_CLK), .ext_addr(EXT_ADDR), .ext_rd_n(EXT_RD_N),
        .ext_wr_n(EXT_WR_N), .ext_data_o(EXT_DATA_O), .ext_data_oe_n(EXT_DATA_OE_N),
        .ext_data_i(EXT_DATA_I));
    // Clock and strobe activity counter
    initial forever #50 SYS_CLK = ~SYS_CLK;
    always @(negedge EXT_RD_N or negedge EXT_WR_N) strobes++;
    // Local fabric selects and writes, counted by their rising edges
    always @(posedge LOC_SEL) locs++;
    always @(posedge LOC_WE) loc_writes++;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // One request held for a single clock edge, then a bounded wait for done
    task automatic acc(input logic w, t, io, input logic [2:0] m, input logic [15:0] a, wd);
        @(posedge SYS_CLK);
        WE <= w;
        TWO_BYTE <= t;
        IO_INSN <= io;
        MODE <= m;
        ADDR <= a;
        WDATA <= wd;
        REQ <= 1'h1;
        lat = 0;
        @(posedge SYS_CLK);
        REQ <= 1'h0;
        do begin
            @(posedge SYS_CLK);
            #1 lat++;
        end while (DONE !== 1'h1 && lat < 40);
        // A hung access must not slip through as a quiet pass
        if (DONE !== 1'h1) begin
            mismatches++;
            $display("[ERR] %0t access never finished", $time);
        end
        rd = RDATA;
    endtask : acc
    task automatic t_map();
        logic [15:0] a [8] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100,
            16'h10FF, 16'h1100};
        logic [2:0] rn [8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4};
        logic [2:0] rc [8] = '{3'h0, 3'h1, 3'h1, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4};
        for (int c = 0; c < 2; c++) begin
            @(posedge SYS_CLK);
            COMPAT_MODE <= c[0];
            for (int i = 0; i < 8; i++) begin
                acc(1'h0, 1'h0, 1'h0, 3'h0, a[i], 16'h0000);
                chk({13'h0, REGION}, {13'h0, c ? rc[i] : rn[i]}, "region");
            end
        end
        @(posedge SYS_CLK);
        COMPAT_MODE <= 1'h0;
        $display("t_map end");
    endtask : t_map
    task automatic t_io();
        int s;
        int l;
        int lw;
        s = strobes;
        l = locs;
        lw = loc_writes;
        acc(1'h0, 1'h0, 1'h1, 3'h0, 16'h00A0, 16'h0000);
        chk({13'h0, REGION}, 16'h0001, "io region low");
        chk(rd, 16'h003C, "io read data");
        acc(1'h1, 1'h0, 1'h1, 3'h0, 16'hFFFF, 16'h0055);
        chk({13'h0, REGION}, 16'h0001, "io region high");
        chk({8'h00, LOC_ADDR}, 16'h005F, "io store address");
        chk({8'h00, LOC_WDATA}, 16'h0055, "io store data");
        acc(1'h1, 1'h1, 1'h0, 3'h0, 16'h10FE, 16'h7788);
        chk(16'(strobes - s), 16'h0000, "internal strobes");
        chk(16'(locs - l), 16'h0002, "local selects");
        chk(16'(loc_writes - lw), 16'h0001, "local writes");
        $display("t_io end");
    endtask : t_io
    task automatic t_off();
        int s;
        @(posedge SYS_CLK);
        EXT_ENABLE <= 1'h0;
        s = strobes;
        acc(1'h1, 1'h1, 1'h0, 3'h0, 16'h2000, 16'hFFFF);
        chk({13'h0, REGION}, 16'h0005, "off region");
        acc(1'h0, 1'h0, 1'h0, 3'h0, 16'hFFFF, 16'h0000);
        chk({15'h0, EXT_BLOCKED}, 16'h0001, "blocked flag");
        chk(rd, 16'h0000, "off read");
        chk(16'(strobes - s), 16'h0000, "off strobes");
        @(posedge SYS_CLK);
        EXT_ENABLE <= 1'h1;
        $display("t_off end");
    endtask : t_off
    task automatic t_wait();
        logic [4:0] e;
        acc(1'h1, 1'h1, 1'h0, 3'h0, 16'h0200, 16'h1234);
        acc(1'h0, 1'h0, 1'h0, 3'h0, 16'h0201, 16'h0000);
        chk(16'(lat), 16'h0002, "internal cycles");
        chk({8'h00, rd[7:0]}, 16'h0012, "internal data");
        for (int c = 0; c < 2; c++) begin
            for (int w = 0; w < 4; w++) begin
                @(posedge SYS_CLK);
                COMPAT_MODE <= c[0];
                WAIT_SEL <= w[1:0];
                e = c ? 5'(w != 0) : 5'(w);
                acc(1'h1, 1'h1, 1'h0, 3'h0, 16'h2010, {8'(8 * c + w), 8'hC3});
                chk(16'(lat), 16'(6 + 2 * e), "pair cycles");
                acc(1'h0, 1'h0, 1'h0, 3'h0, 16'h2011, 16'h0000);
                chk(16'(lat), 16'(3 + e), "byte cycles");
                chk({8'h00, rd[7:0]}, 16'(8 * c + w), "high byte");
            end
        end
        chk({8'h00, ext_u.mem[8'h10]}, 16'h00C3, "low byte");
        @(posedge SYS_CLK);
        COMPAT_MODE <= 1'h0;
        WAIT_SEL <= 2'h0;
        $display("t_wait end");
    endtask : t_wait
    task automatic t_ptr();
        acc(1'h1, 1'h1, 1'h0, 3'h0, 16'h001C, 16'h2000);
        acc(1'h1, 1'h1, 1'h0, 3'h0, 16'h001A, 16'h3000);
        acc(1'h1, 1'h1, 1'h0, 3'h0, 16'h001E, 16'h4000);
        chk(PTR_Y, 16'h2000, "pointer load");
        @(posedge SYS_CLK);
        PTR_SEL <= 2'h1;
        DISP <= 6'h3F;
        acc(1'h0, 1'h0, 1'h0, 3'h1, 16'h0000, 16'h0000);
        chk(EXT_ADDR, 16'h203F, "displacement");
        @(posedge SYS_CLK);
        PTR_SEL <= 2'h0;
        acc(1'h0, 1'h0, 1'h0, 3'h4, 16'h0000, 16'h0000);
        chk(EXT_ADDR, 16'h3000, "postinc addr");
        chk(PTR_X, 16'h3001, "postinc ptr");
        @(posedge SYS_CLK);
        PTR_SEL <= 2'h2;
        acc(1'h1, 1'h0, 1'h0, 3'h3, 16'h0000, 16'h0066);
        chk(EXT_ADDR, 16'h3FFF, "predec addr");
        chk(PTR_Z, 16'h3FFF, "predec ptr");
        acc(1'h0, 1'h0, 1'h0, 3'h2, 16'h0000, 16'h0000);
        chk(EXT_ADDR, 16'h3FFF, "indirect addr");
        chk(PTR_Z, 16'h3FFF, "indirect keeps ptr");
        chk(rd, 16'h0066, "predec store data");
        $display("t_ptr end");
    endtask : t_ptr
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    // Main sequence after twelve cycles of reset
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RST_N <= 1'h1;
        t_map();
        t_io();
        t_off();
        t_wait();
        t_ptr();
        complete_run();
    end
    // About 300 cycles expected, cut off well beyond
    initial begin
        #400000;
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
endmodule : dmm_data_access_tb_top
